// [hdl/lmsd_decoder.v]
`timescale 1ns/10ps
`default_nettype none
`include "lmsd_regs.vh"

module lmsd_decoder #(
    parameter PADDR_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [PADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Cycle to be steered
    input wire reqValid,
    input wire [31:0] reqAddr,
    input wire reqIo,
    input wire reqWrite,
    input wire reqSmm,
    input wire [1:0] reqSource,
    // Steering decision
    output reg routeDram,
    output reg routeHub,
    output reg routeGfx,
    output reg masterAbort,
    output wire [1:0] frameWithheld
);

    // ****************************************
    // Register storage
    // ****************************************
    // Attribute maps, two nibbles each
    reg [7:0] sysBiosAttr;
    reg [7:0] addonAttrC0;
    reg [7:0] addonAttrC8;
    reg [7:0] addonAttrD0;
    reg [7:0] addonAttrD8;
    reg [7:0] extAttrE0;
    reg [7:0] extAttrE8;
    // Control and configuration bits
    reg [7:0] smramCtl;
    reg monoEnable;
    reg gfxPortOn;
    reg bridgeCmdVga;
    reg bridgeCtrlVga;
    // Last steering decision, for status reads
    reg [3:0] lastRoute;

    // Bus decode
    wire [9:0] regIdx;
    wire accessPhase;
    wire setupPhase;
    wire wrStrobe;
    reg idxHit;
    reg [31:0] next_prdata;

    // ****************************************
    // Helpers
    // ****************************************
    // Keep only the write and read enables of a two-nibble register
    function [7:0] attrMask;
        input [7:0] value;
        begin
            attrMask = value & 8'h33;
        end
    endfunction

    // Pick the enable for the cycle direction out of a nibble
    function attrPick;
        input [3:0] nibble;
        input isWrite;
        begin
            attrPick = isWrite ? nibble[`LMSD_NIB_WE] : nibble[`LMSD_NIB_RE];
        end
    endfunction

    // Cycle comes from the processor bus
    function srcIsCpu;
        input [1:0] source;
        begin
            srcIsCpu = (source == `LMSD_SRC_CPU);
        end
    endfunction

    // Match one of the monochrome adapter I/O ports
    function monoPortHit;
        input [31:0] port;
        begin
            case (port)
                32'h000003B4, 32'h000003B5, 32'h000003B8: monoPortHit = 1'b1;
                32'h000003B9, 32'h000003BA, 32'h000003BF: monoPortHit = 1'b1;
                default: monoPortHit = 1'b0;
            endcase
        end
    endfunction

    // ****************************************
    // APB decode
    // ****************************************
    assign regIdx = paddr[11:2];
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    // Zero-wait slave, never stretched
    assign pready = 1'b1;
    assign wrStrobe = accessPhase & pwrite & idxHit;
    assign pslverr = accessPhase & ~idxHit;

    // Address hit check and read mux
    always @*
    begin
        idxHit = 1'b1;
        next_prdata = 32'h00000000;
        // Misaligned words are refused
        if (paddr[1:0] != 2'h0)
        begin
            idxHit = 1'b0;
        end
        else
        begin
            case (regIdx)
                `LMSD_IDX_SYS_BIOS: next_prdata[7:0] = sysBiosAttr;
                `LMSD_IDX_ADDON_C0: next_prdata[7:0] = addonAttrC0;
                `LMSD_IDX_ADDON_C8: next_prdata[7:0] = addonAttrC8;
                `LMSD_IDX_ADDON_D0: next_prdata[7:0] = addonAttrD0;
                `LMSD_IDX_ADDON_D8: next_prdata[7:0] = addonAttrD8;
                `LMSD_IDX_EXT_E0: next_prdata[7:0] = extAttrE0;
                `LMSD_IDX_EXT_E8: next_prdata[7:0] = extAttrE8;
                `LMSD_IDX_SYSMGMT_RAM_CONTROL: next_prdata[7:0] = smramCtl;
                `LMSD_IDX_MONO: next_prdata[`LMSD_MONO_EN] = monoEnable;
                `LMSD_IDX_PORT_CFG: next_prdata[`LMSD_PORT_ON] = gfxPortOn;
                `LMSD_IDX_BRIDGE_CMD: next_prdata[`LMSD_BRIDGE_CMD_VGA] = bridgeCmdVga;
                `LMSD_IDX_BRIDGE_CTRL: next_prdata[`LMSD_BRIDGE_CTRL_VGA] = bridgeCtrlVga;
                `LMSD_IDX_STATUS: next_prdata[3:0] = lastRoute;
                default: idxHit = 1'b0;
            endcase
        end
    end

    // Read data captured in the setup cycle, held through access
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
        end
        else if (setupPhase)
        begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sysBiosAttr <= `LMSD_ATTR_RESET;
            addonAttrC0 <= `LMSD_ATTR_RESET;
            addonAttrC8 <= `LMSD_ATTR_RESET;
            addonAttrD0 <= `LMSD_ATTR_RESET;
            addonAttrD8 <= `LMSD_ATTR_RESET;
            extAttrE0 <= `LMSD_ATTR_RESET;
            extAttrE8 <= `LMSD_ATTR_RESET;
            smramCtl <= `LMSD_SYSMGMT_RAM_CONTROL_RESET;
            monoEnable <= `LMSD_CFG_RESET;
            gfxPortOn <= `LMSD_CFG_RESET;
            bridgeCmdVga <= `LMSD_CFG_RESET;
            bridgeCtrlVga <= `LMSD_CFG_RESET;
        end
        else if (wrStrobe)
        begin
            case (regIdx)
                // Attribute registers keep only their enable bits
                `LMSD_IDX_SYS_BIOS: sysBiosAttr <= attrMask(pwdata[7:0]) & 8'hF0;
                `LMSD_IDX_ADDON_C0: addonAttrC0 <= attrMask(pwdata[7:0]);
                `LMSD_IDX_ADDON_C8: addonAttrC8 <= attrMask(pwdata[7:0]);
                `LMSD_IDX_ADDON_D0: addonAttrD0 <= attrMask(pwdata[7:0]);
                `LMSD_IDX_ADDON_D8: addonAttrD8 <= attrMask(pwdata[7:0]);
                `LMSD_IDX_EXT_E0: extAttrE0 <= attrMask(pwdata[7:0]);
                `LMSD_IDX_EXT_E8: extAttrE8 <= attrMask(pwdata[7:0]);
                `LMSD_IDX_SYSMGMT_RAM_CONTROL:
                begin
                    // Mode select frozen once locked; lock only sets
                    if (!smramCtl[`LMSD_SYSMGMT_RAM_CONTROL_LOCK])
                    begin
                        smramCtl[7:6] <= pwdata[7:6];
                    end
                    smramCtl[5:2] <= pwdata[5:2];
                    // Lock stays set until reset
                    smramCtl[1] <= smramCtl[1] | pwdata[1];
                    // Bit 0 always reads zero
                    smramCtl[0] <= 1'b0;
                end
                // Single configuration bits
                `LMSD_IDX_MONO: monoEnable <= pwdata[`LMSD_MONO_EN];
                `LMSD_IDX_PORT_CFG: gfxPortOn <= pwdata[`LMSD_PORT_ON];
                `LMSD_IDX_BRIDGE_CMD: bridgeCmdVga <= pwdata[`LMSD_BRIDGE_CMD_VGA];
                `LMSD_IDX_BRIDGE_CTRL: bridgeCtrlVga <= pwdata[`LMSD_BRIDGE_CTRL_VGA];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Steering decision
    // ****************************************
    wire [5:0] seg;
    wire below1M;
    wire inDos;
    wire inVideo;
    wire inMono;
    wire monoPort;
    wire [1:0] graphics_mode_select;
    wire videoToGfx;
    reg [3:0] segNibble;
    reg segEnabled;

    // Address classification below 1 MB
    assign seg = reqAddr[19:14];
    assign below1M = (reqAddr[31:20] == 12'h000);
    assign inDos = below1M & (seg < `LMSD_SEG_VIDEO_LO);
    assign inVideo = below1M & (seg >= `LMSD_SEG_VIDEO_LO) & (seg < `LMSD_SEG_EXP_LO);
    assign inMono = inVideo & ((seg == `LMSD_SEG_MONO_LO) | (seg == `LMSD_SEG_MONO_HI));
    assign monoPort = monoPortHit(reqAddr);
    assign graphics_mode_select = smramCtl[`LMSD_SYSMGMT_RAM_CONTROL_GMS_HI:`LMSD_SYSMGMT_RAM_CONTROL_GMS_LO];
    // Mode select ignored while the port is on
    assign videoToGfx = gfxPortOn ? (bridgeCmdVga & bridgeCtrlVga) : (graphics_mode_select != 2'h0);
    // Withheld frame memory: 0 none, 1 none, 2 half MB, 3 one MB
    assign frameWithheld = gfxPortOn ? 2'h0 : graphics_mode_select;

    // Attribute nibble by segment
    always @*
    begin
        case (seg)
            6'h30: segNibble = addonAttrC0[3:0];
            6'h31: segNibble = addonAttrC0[7:4];
            6'h32: segNibble = addonAttrC8[3:0];
            6'h33: segNibble = addonAttrC8[7:4];
            6'h34: segNibble = addonAttrD0[3:0];
            6'h35: segNibble = addonAttrD0[7:4];
            6'h36: segNibble = addonAttrD8[3:0];
            6'h37: segNibble = addonAttrD8[7:4];
            6'h38: segNibble = extAttrE0[3:0];
            6'h39: segNibble = extAttrE0[7:4];
            6'h3A: segNibble = extAttrE8[3:0];
            6'h3B: segNibble = extAttrE8[7:4];
            6'h3C, 6'h3D, 6'h3E, 6'h3F: segNibble = sysBiosAttr[7:4];
            default: segNibble = 4'h0;
        endcase
        // Enable bit for the cycle direction
        segEnabled = attrPick(segNibble, reqWrite);
    end

    // Route selection
    always @*
    begin
        // Nothing claimed unless a branch below takes the cycle
        routeDram = 1'b0;
        routeHub = 1'b0;
        routeGfx = 1'b0;
        masterAbort = 1'b0;
        if (reqValid)
        begin
            if (reqIo)
            begin
                // Only the mono adapter ports are claimed
                routeHub = monoEnable & monoPort;
            end
            else if (!below1M)
            begin
                // Left to the decoders above 1 MB
                routeDram = 1'b0;
            end
            else if (inDos)
            begin
                // DOS area ignores every attribute
                routeDram = 1'b1;
            end
            else if (inVideo)
            begin
                // Video buffer: attributes play no part
                if (reqSource == `LMSD_SRC_GFX)
                begin
                    masterAbort = 1'b1;
                end
                else if (monoEnable & inMono)
                begin
                    routeHub = srcIsCpu(reqSource);
                end
                else if (srcIsCpu(reqSource) & reqSmm & smramCtl[`LMSD_SYSMGMT_RAM_CONTROL_COMPAT_OPEN])
                begin
                    routeDram = 1'b1;
                end
                else if (videoToGfx)
                begin
                    // Hub reads abort; processor cycles and hub writes go to graphics
                    if ((reqSource == `LMSD_SRC_HUB) & !reqWrite)
                    begin
                        masterAbort = 1'b1;
                    end
                    else
                    begin
                        routeGfx = 1'b1;
                    end
                end
                else
                begin
                    // Processor cycles only; other initiators unclaimed
                    routeHub = srcIsCpu(reqSource);
                end
            end
            else if (segEnabled)
            begin
                // Expansion and BIOS areas follow the attribute bit
                routeDram = 1'b1;
            end
            else
            begin
                // Disabled segment: processor cycles forwarded unrelocated, other initiators unclaimed
                routeHub = srcIsCpu(reqSource);
            end
        end
    end

    // ****************************************
    // Last decision, visible in the status register
    // ****************************************
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lastRoute <= 4'h0;
        end
        else if (reqValid)
        begin
            lastRoute <= {masterAbort, routeGfx, routeHub, routeDram};
        end
    end

endmodule // lmsd_decoder

`default_nettype wire

// [hdl/lmsd_regs.vh]
`ifndef LMSD_REGS_VH
`define LMSD_REGS_VH

// ****************************************
// Register indexes (byte address = index * 4)
// ****************************************
`define LMSD_IDX_SYS_BIOS 10'h059
`define LMSD_IDX_ADDON_C0 10'h05A
`define LMSD_IDX_ADDON_C8 10'h05B
`define LMSD_IDX_ADDON_D0 10'h05C
`define LMSD_IDX_ADDON_D8 10'h05D
`define LMSD_IDX_EXT_E0 10'h05E
`define LMSD_IDX_EXT_E8 10'h05F
`define LMSD_IDX_SYSMGMT_RAM_CONTROL 10'h070
`define LMSD_IDX_MONO 10'h0BE
`define LMSD_IDX_PORT_CFG 10'h080
`define LMSD_IDX_BRIDGE_CMD 10'h081
`define LMSD_IDX_BRIDGE_CTRL 10'h082
`define LMSD_IDX_STATUS 10'h083

// ****************************************
// Field positions
// ****************************************
`define LMSD_NIB_RE 0
`define LMSD_NIB_WE 1
`define LMSD_SYSMGMT_RAM_CONTROL_GMS_HI 7
`define LMSD_SYSMGMT_RAM_CONTROL_GMS_LO 6
`define LMSD_SYSMGMT_RAM_CONTROL_COMPAT_OPEN 3
`define LMSD_SYSMGMT_RAM_CONTROL_LOCK 1
`define LMSD_MONO_EN 0
`define LMSD_PORT_ON 0
`define LMSD_BRIDGE_CMD_VGA 5
`define LMSD_BRIDGE_CTRL_VGA 3

// ****************************************
// Reset values
// ****************************************
`define LMSD_ATTR_RESET 8'h00
`define LMSD_SYSMGMT_RAM_CONTROL_RESET 8'h00
`define LMSD_CFG_RESET 1'b0

// ****************************************
// Address map below 1 MB (address bits 19:14)
// ****************************************
`define LMSD_SEG_VIDEO_LO 6'h28
`define LMSD_SEG_MONO_LO 6'h2C
`define LMSD_SEG_MONO_HI 6'h2D
`define LMSD_SEG_EXP_LO 6'h30
`define LMSD_SEG_SYS_BIOS 6'h3C

// ****************************************
// Initiators
// ****************************************
`define LMSD_SRC_CPU 2'h0
`define LMSD_SRC_HUB 2'h1
`define LMSD_SRC_GFX 2'h2

`endif

// [verification/lmsd_decoder_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Steering checker
// ****************************************
module lmsd_decoder_chk #(
    parameter PADDR_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // Cycle and decision
    input wire logic reqValid,
    input wire logic [31:0] reqAddr,
    input wire logic reqIo,
    input wire logic reqWrite,
    input wire logic reqSmm,
    input wire logic [1:0] reqSource,
    input wire logic routeDram,
    input wire logic routeHub,
    input wire logic routeGfx,
    input wire logic masterAbort,
    input wire logic [1:0] frameWithheld
);
    logic [1:0] mode;
    logic lock, portOn, monoEn, biosRd, biosWr;
    wire wr = psel && penable && pwrite && !pslverr;
    wire [9:0] idx = paddr[11:2];
    wire mem = reqValid && !reqIo;
    wire vid = mem && reqAddr[31:17] == 15'h0005;
    wire bios = mem && reqAddr[31:16] == 16'h000F && reqSource == 2'h0;
    // Shadow of the steering fields
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= 2'h0;
            lock <= 1'h0;
            portOn <= 1'h0;
            monoEn <= 1'h0;
            biosRd <= 1'h0;
            biosWr <= 1'h0;
        end
        else if (wr)
        begin
            if (idx == 10'h070 && !lock)
                mode <= pwdata[7:6];
            if (idx == 10'h070)
                lock <= lock | pwdata[1];
            if (idx == 10'h080)
                portOn <= pwdata[0];
            if (idx == 10'h0BE)
                monoEn <= pwdata[0];
            if (idx == 10'h059)
            begin
                biosRd <= pwdata[4];
                biosWr <= pwdata[5];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_low_dram: assert property (mem && reqAddr < 32'h000A0000 |-> routeDram && !routeHub && !routeGfx)
        else $error("low region not sent to dram");
    a_video_nodram: assert property (vid && !reqSmm |-> !routeDram)
        else $error("video cycle sent to dram");
    a_gfx_abort: assert property (vid && reqSource == 2'h2 |-> masterAbort && !routeGfx)
        else $error("graphics video cycle not aborted");
    a_mono_mem: assert property (vid && reqAddr[16:15] == 2'h2 && monoEn && reqSource == 2'h0 |-> routeHub)
        else $error("mono range not forwarded");
    a_mono_io: assert property (reqValid && reqIo && routeHub |-> monoEn)
        else $error("io forwarded without mono enable");
    a_bios_read: assert property (bios && !reqWrite |-> routeDram == biosRd && routeHub == !biosRd)
        else $error("bios read steering wrong");
    a_bios_write: assert property (bios && reqWrite |-> routeDram == biosWr && routeHub == !biosWr)
        else $error("bios write steering wrong");
    a_frame_mode: assert property (frameWithheld == (portOn ? 2'h0 : mode))
        else $error("withheld size wrong");
    a_route_single: assert property (reqValid |-> $onehot0({routeDram, routeHub, routeGfx}))
        else $error("several routes at once");
    // Main scenarios reached
    cover property (vid && routeGfx);
    cover property (masterAbort);
    cover property (bios && routeDram);
endmodule // lmsd_decoder_chk
`default_nettype wire

// [verification/lmsd_decoder_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lmsd_regs.vh"
module lmsd_decoder_tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, reqAddr, q;
    logic reqValid, reqIo, reqWrite, reqSmm, routeDram, routeHub, routeGfx, masterAbort;
    logic [1:0] reqSource, frameWithheld;
    int errors, checks_done, i;
    lmsd_decoder u_lmsd_decoder (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reqValid(reqValid), .reqAddr(reqAddr), .reqIo(reqIo), .reqWrite(reqWrite), .reqSmm(reqSmm),
        .reqSource(reqSource), .routeDram(routeDram), .routeHub(routeHub), .routeGfx(routeGfx),
        .masterAbort(masterAbort), .frameWithheld(frameWithheld));
    lmsd_initiator_model u_lmsd_initiator_model (.clk(clk), .reqValid(reqValid), .reqAddr(reqAddr),
        .reqIo(reqIo), .reqWrite(reqWrite), .reqSmm(reqSmm), .reqSource(reqSource), .routeDram(routeDram),
        .routeHub(routeHub), .routeGfx(routeGfx), .masterAbort(masterAbort));
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Final report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One APB transfer, read data into q and error into e
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1)
        begin
            errors++;
            give_verdict();
        end
    endtask
    // One steered cycle against its expected decision
    task automatic cy(input logic [1:0] s, input logic io, w, m, input logic [31:0] a, input logic [3:0] x);
        logic [3:0] r;
        u_lmsd_initiator_model.issue(s, io, w, m, a, r);
        chk("route", {28'h0, r}, {28'h0, x});
    endtask
    // Reset values, low region, unmapped place
    task automatic t_reset();
        for (i = 'h59; i < 'h60; i++)
        begin
            apb(1'h0, 10'(i), 8'h00);
            chk("attr", q, 32'h0);
        end
        apb(1'h0, 10'h070, 8'h00);
        chk("ctrl", q, 32'h0);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000F0000, 4'h2);
        cy(2'h0, 1'h0, 1'h1, 1'h0, 32'h000FFFFC, 4'h2);
        apb(1'h0, `LMSD_IDX_STATUS, 8'h00);
        chk("status", q, 32'h2);
        for (i = 0; i < 3; i++)
            cy(2'(i), 1'h0, 1'(i), 1'h0, 32'h0009FFFC, 4'h4);
        apb(1'h0, 10'h3FF, 8'h00);
        chk("unmapped", {31'h0, e}, 32'h1);
        $display("reset test done");
    endtask
    // Every attribute segment, read and write independently
    task automatic t_attr();
        logic [31:0] a;
        logic [9:0] idx;
        int s;
        int sh;
        for (s = 0; s < 13; s++)
        begin
            a = (s == 0) ? 32'h000F0000 : 32'h000C0000 + (s - 1) * 32'h4000;
            idx = 10'(`LMSD_IDX_SYS_BIOS + (s + 1) / 2);
            sh = (s % 2 == 0) ? 4 : 0;
            apb(1'h1, idx, 8'h01 << sh);
            cy(2'h0, 1'h0, 1'h0, 1'h0, a + 32'h3FFC, 4'h4);
            cy(2'h0, 1'h0, 1'h1, 1'h0, a, 4'h2);
            apb(1'h1, idx, 8'h02 << sh);
            cy(2'h0, 1'h0, 1'h0, 1'h0, a, 4'h2);
            cy(2'h0, 1'h0, 1'h1, 1'h0, a, 4'h4);
            apb(1'h1, idx, 8'h00);
            cy(2'h0, 1'h0, 1'h1, 1'h0, a, 4'h2);
            cy(2'h1, 1'h0, 1'h1, 1'h0, a, 4'h0);
        end
        $display("attribute test done");
    endtask
    // Video region by mode select, bridge bits and initiator
    task automatic t_video();
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000A0000, 4'h2);
        for (i = 1; i < 4; i++)
        begin
            apb(1'h1, 10'h070, 8'(i << 6));
            @(negedge clk);
            chk("frame", {30'h0, frameWithheld}, 32'(i));
            cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000BFFFC, 4'h1);
            cy(2'h1, 1'h0, 1'h1, 1'h0, 32'h000A0000, 4'h1);
            cy(2'h1, 1'h0, 1'h0, 1'h0, 32'h000A0000, 4'h8);
            cy(2'h2, 1'h0, 1'h1, 1'h0, 32'h000A0000, 4'h8);
        end
        apb(1'h1, 10'h070, 8'h88);
        cy(2'h0, 1'h0, 1'h0, 1'h1, 32'h000A0000, 4'h4);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000A0000, 4'h1);
        apb(1'h1, 10'h080, 8'h01);
        @(negedge clk);
        chk("frame", {30'h0, frameWithheld}, 32'h0);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000A0000, 4'h2);
        apb(1'h1, 10'h081, 8'h20);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000A0000, 4'h2);
        apb(1'h1, 10'h082, 8'h08);
        apb(1'h0, 10'h081, 8'h00);
        chk("bridge", q, 32'h20);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000A0000, 4'h1);
        apb(1'h1, 10'h080, 8'h00);
        $display("video test done");
    endtask
    // Monochrome memory and ports
    task automatic t_mono();
        logic [11:0] ports [6] = '{12'h3B4, 12'h3B5, 12'h3B8, 12'h3B9, 12'h3BA, 12'h3BF};
        apb(1'h1, `LMSD_IDX_MONO, 8'h01);
        apb(1'h0, `LMSD_IDX_MONO, 8'h00);
        chk("mono", q, 32'h1);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000B7FFC, 4'h2);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000B8000, 4'h1);
        for (i = 0; i < 6; i++)
            cy(2'h0, 1'h1, 1'h1, 1'h0, {20'h0, ports[i]}, 4'h2);
        cy(2'h0, 1'h1, 1'h0, 1'h0, 32'h000003B6, 4'h0);
        apb(1'h1, `LMSD_IDX_MONO, 8'h00);
        cy(2'h0, 1'h1, 1'h0, 1'h0, 32'h000003B4, 4'h0);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000B0000, 4'h1);
        $display("mono test done");
    endtask
    // Lock freezes mode select
    task automatic t_lock();
        apb(1'h1, 10'h070, 8'h82);
        apb(1'h1, 10'h070, 8'hC0);
        apb(1'h0, 10'h070, 8'h00);
        chk("ctrl", q, 32'h82);
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        apb(1'h0, 10'h070, 8'h00);
        chk("ctrl", q, 32'h0);
        cy(2'h0, 1'h0, 1'h0, 1'h0, 32'h000F0000, 4'h2);
        $display("lock test done");
    endtask
    // Clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Main sequence
    initial
    begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_attr();
        t_video();
        t_mono();
        t_lock();
        give_verdict();
    end
endmodule // lmsd_decoder_tb
bind lmsd_decoder lmsd_decoder_chk #(.PADDR_W(PADDR_W)) u_lmsd_decoder_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqIo(reqIo), .reqWrite(reqWrite), .reqSmm(reqSmm),
    .reqSource(reqSource), .routeDram(routeDram), .routeHub(routeHub), .routeGfx(routeGfx),
    .masterAbort(masterAbort), .frameWithheld(frameWithheld));
`default_nettype wire

// [verification/lmsd_initiator_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Processor, hub and graphics initiators
// ****************************************
module lmsd_initiator_model (
    // Clock
    input wire logic clk,
    // Cycle to be steered
    output logic reqValid,
    output logic [31:0] reqAddr,
    output logic reqIo,
    output logic reqWrite,
    output logic reqSmm,
    output logic [1:0] reqSource,
    // Decision seen
    input wire logic routeDram,
    input wire logic routeHub,
    input wire logic routeGfx,
    input wire logic masterAbort
);
    // Idle at time zero
    initial
    begin
        reqValid = 1'h0;
        reqAddr = 32'h0;
        reqIo = 1'h0;
        reqWrite = 1'h0;
        reqSmm = 1'h0;
        reqSource = 2'h0;
    end
    // One cycle, decision as abort, dram, hub, graphics
    task automatic issue(input logic [1:0] s, input logic io, w, m, input logic [31:0] a, output logic [3:0] r);
        @(posedge clk);
        reqValid <= 1'h1;
        reqAddr <= a;
        reqIo <= io;
        reqWrite <= w; // Hub video reads only when the bench asks for one
        reqSmm <= m;
        reqSource <= s;
        @(negedge clk);
        r = {masterAbort, routeDram, routeHub, routeGfx};
        @(posedge clk);
        reqValid <= 1'h0;
        reqAddr <= ~a; // Released address does not keep its value
    endtask
endmodule // lmsd_initiator_model
`default_nettype wire
